/* dmsm_pkg.sv */
// Package: shared constants and types of the data mode and symbol mapper
package dmsm_pkg;
    // Register indices on the plain register port
    localparam logic [7:0] A_PACKET_CONFIG_TWO = 8'h00;
    localparam logic [7:0] A_SYNC_CONFIG_ONE   = 8'h01;
    localparam logic [7:0] A_MODEM_CONFIG_ONE  = 8'h02;
    localparam logic [7:0] A_MODEM_CONFIG_TWO  = 8'h03;
    localparam logic [7:0] A_MOD_AND_EXP       = 8'h04;
    localparam logic [7:0] A_DEV_MANTISSA      = 8'h05;
    localparam logic [7:0] A_LINK_STATUS       = 8'h06;
    localparam logic [7:0] A_DEV_VALUE_LO      = 8'h07;
    localparam logic [7:0] A_DEV_VALUE_HI      = 8'h08;

    // Packet format selector codes
    localparam logic [1:0] FMT_FIFO  = 2'h0;
    localparam logic [1:0] FMT_SER   = 2'h1;
    localparam logic [1:0] FMT_TRANS = 2'h3;

    // Modulation scheme field codes
    localparam logic [2:0] MOD_2FSK  = 3'h0;
    localparam logic [2:0] MOD_2GFSK = 3'h1;
    localparam logic [2:0] MOD_ASK   = 3'h3;
    localparam logic [2:0] MOD_4FSK  = 3'h4;
    localparam logic [2:0] MOD_4GFSK = 3'h5;

    // Sync word mode meaning no sync insertion or detection
    localparam logic [2:0] SYNC_MODE_NONE = 3'h0;

    // Values after reset
    localparam logic [1:0] FMT_RST       = 2'h0;
    localparam logic [2:0] SYNC_MODE_RST = 3'h2;
    localparam logic [1:0] MAP_RST       = 2'h0;
    localparam logic [2:0] MOD_RST       = 3'h0;
    localparam logic [2:0] DEV_E_RST     = 3'h0;
    localparam logic [7:0] DEV_M_RST     = 8'h00;

    // Link clock cycles per half period of the serial bit clock
    localparam int SER_HALF_CYC = 4;

    // Configuration word carried into the link domain
    typedef struct packed {
        logic [1:0] fmt;
        logic [2:0] sync_mode;
        logic       man;
        logic [1:0] map;
        logic [2:0] mod;
    } dmsm_cfg_t;

    localparam dmsm_cfg_t CFG_RST = '{fmt: FMT_RST, sync_mode: SYNC_MODE_RST,
                                      man: 1'h0, map: MAP_RST, mod: MOD_RST};

    // Transmit symbol: lvl 0..3 = -dev, -dev/3, +dev/3, +dev; amplitude = lvl[1]
    typedef struct packed {
        logic       hdr;
        logic       ask;
        logic       shaped;
        logic [1:0] lvl;
    } dmsm_sym_t;

    // Received bits toward the receive buffer, bits[1] first when cnt is 2
    typedef struct packed {
        logic [1:0] cnt;
        logic [1:0] bits;
    } dmsm_rxb_t;
endpackage : dmsm_pkg

/* dmsm_mapper.sv */
// Module: data mode selection, Manchester coding and symbol mapping
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
module dmsm_mapper #(
    parameter int SER_DIV = dmsm_pkg::SER_HALF_CYC
) (
    input  wire logic           mclk,
    input  wire logic           sys_rst,
    input  wire logic [7:0]     reg_addr,
    input  wire logic [7:0]     reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic [7:0]          reg_rdata,
    output logic [15:0]         dev_units,
    input  wire logic           link_clk,
    input  wire logic           tx_active,
    input  wire logic           tx_hdr,
    input  wire logic           tx_bit_valid,
    input  wire logic           tx_bit,
    output logic                tx_bit_ready,
    output dmsm_pkg::dmsm_sym_t tx_sym,
    output logic                tx_sym_valid,
    input  wire logic           rx_active,
    input  wire logic           rx_sync,
    input  wire logic           rx_hdr,
    input  wire logic           rx_sym_valid,
    input  wire logic [1:0]     rx_sym_lvl,
    input  wire logic           rx_hard,
    output dmsm_pkg::dmsm_rxb_t rx_bits,
    output logic                ser_clk,
    output logic                ser_rx_data,
    input  wire logic           ser_tx_data,
    output logic                raw_baseband
);

    ////////////////////////////////////////////////////////////////////////
    // Register domain (mclk)

    dmsm_pkg::dmsm_cfg_t cfg_q;
    logic [2:0]          dev_e_q;
    logic [7:0]          dev_m_q;
    logic [15:0]         dev_q;
    logic                cfg_tog_q;
    logic [7:0]          rdata_q;
    logic [2:0]          st_s1_q;
    logic [2:0]          st_s2_q;
    logic [2:0]          st_l_q;      // Link-side status levels, crossed below

    // Deviation in units of crystal frequency / 2^22
    function automatic logic [15:0] dev_calc(input logic [7:0] m, input logic [2:0] e);
        logic [15:0] base;
        base = {7'h00, 1'h1, m};
        if (e == 3'h0) begin
            dev_calc = {7'h00, m, 1'h0};
        end else begin
            dev_calc = base << e;
        end
    endfunction : dev_calc

    // Address decode
    wire logic wr_pkt = reg_wr && (reg_addr == dmsm_pkg::A_PACKET_CONFIG_TWO);
    wire logic wr_syn = reg_wr && (reg_addr == dmsm_pkg::A_SYNC_CONFIG_ONE);
    wire logic wr_mc1 = reg_wr && (reg_addr == dmsm_pkg::A_MODEM_CONFIG_ONE);
    wire logic wr_mc2 = reg_wr && (reg_addr == dmsm_pkg::A_MODEM_CONFIG_TWO);
    wire logic wr_mex = reg_wr && (reg_addr == dmsm_pkg::A_MOD_AND_EXP);
    wire logic wr_man = reg_wr && (reg_addr == dmsm_pkg::A_DEV_MANTISSA);
    wire logic wr_cfg = wr_pkt || wr_syn || wr_mc1 || wr_mc2 || wr_mex;

    // Read selection, unmapped reads as zero
    wire logic [7:0] rd_mux =
        (reg_addr == dmsm_pkg::A_PACKET_CONFIG_TWO) ? {6'h00, cfg_q.fmt} :
        (reg_addr == dmsm_pkg::A_SYNC_CONFIG_ONE)   ? {5'h00, cfg_q.sync_mode} :
        (reg_addr == dmsm_pkg::A_MODEM_CONFIG_ONE)  ? {7'h00, cfg_q.man} :
        (reg_addr == dmsm_pkg::A_MODEM_CONFIG_TWO)  ? {6'h00, cfg_q.map} :
        (reg_addr == dmsm_pkg::A_MOD_AND_EXP)       ? {2'h0, cfg_q.mod, dev_e_q} :
        (reg_addr == dmsm_pkg::A_DEV_MANTISSA)      ? dev_m_q :
        (reg_addr == dmsm_pkg::A_LINK_STATUS)       ? {5'h00, st_s2_q} :
        (reg_addr == dmsm_pkg::A_DEV_VALUE_LO)      ? dev_q[7:0] :
        (reg_addr == dmsm_pkg::A_DEV_VALUE_HI)      ? dev_q[15:8] : 8'h00;

    // Configuration registers; a write to any of them but the mantissa flips the crossing toggle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_q     <= dmsm_pkg::CFG_RST;
            dev_e_q   <= dmsm_pkg::DEV_E_RST;
            dev_m_q   <= dmsm_pkg::DEV_M_RST;
            cfg_tog_q <= 1'h0;
        end else begin
            if (wr_pkt) cfg_q.fmt <= reg_wdata[1:0];
            if (wr_syn) cfg_q.sync_mode <= reg_wdata[2:0];
            if (wr_mc1) cfg_q.man <= reg_wdata[0];
            if (wr_mc2) cfg_q.map <= reg_wdata[1:0];
            if (wr_mex) begin
                cfg_q.mod <= reg_wdata[5:3];
                dev_e_q   <= reg_wdata[2:0];
            end
            if (wr_man) dev_m_q <= reg_wdata;
            if (wr_cfg) cfg_tog_q <= ~cfg_tog_q;
        end
    end

    // Deviation value, one setting for both directions
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dev_q <= 16'h0000;
        end else begin
            dev_q <= dev_calc(dev_m_q, dev_e_q);
        end
    end

    // Read data for one cycle; status levels pass two flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
            st_s1_q <= 3'h0;
            st_s2_q <= 3'h0;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
            st_s1_q <= st_l_q;
            st_s2_q <= st_s1_q;
        end
    end

    assign reg_rdata = rdata_q;
    assign dev_units = dev_q;

    ////////////////////////////////////////////////////////////////////////
    // Link domain (link_clk)

    logic                rs1_q, lrst;
    logic                tg1_q, tg2_q, tg3_q;
    logic                sd1_q, sd2_q;
    dmsm_pkg::dmsm_cfg_t cfl_q;
    logic [3:0]          div_q;
    logic                sclk_q, sdat_q, raw_q;
    logic                half_q, held_q, pair_q, first_q;
    dmsm_pkg::dmsm_sym_t sym_q;
    logic                sym_v_q;
    dmsm_pkg::dmsm_rxb_t rxb_q;
    logic                rph_q;
    logic [1:0]          pq_q, pc_q;

    // Level code for a dibit under a symbol map
    function automatic logic [1:0] map_lvl(input logic [1:0] d, input logic [1:0] m);
        logic s, o;
        s = d[1] ^ m[1];
        o = d[0] ^ m[0];
        map_lvl = {s, s ^ ~o};
    endfunction : map_lvl

    // Dibit for a level code under a symbol map
    function automatic logic [1:0] unmap_lvl(input logic [1:0] c, input logic [1:0] m);
        unmap_lvl = {c[1] ^ m[1], ~(c[1] ^ c[0]) ^ m[0]};
    endfunction : unmap_lvl

    // Mode decode
    wire logic is_ser = cfl_q.fmt == dmsm_pkg::FMT_SER;
    wire logic is_fif = cfl_q.fmt == dmsm_pkg::FMT_FIFO;
    wire logic is_trn = cfl_q.fmt == dmsm_pkg::FMT_TRANS;
    wire logic blind  = is_ser && cfl_q.sync_mode == dmsm_pkg::SYNC_MODE_NONE;
    wire logic four   = cfl_q.mod == dmsm_pkg::MOD_4FSK || cfl_q.mod == dmsm_pkg::MOD_4GFSK;
    wire logic gauss  = cfl_q.mod == dmsm_pkg::MOD_2GFSK || cfl_q.mod == dmsm_pkg::MOD_4GFSK;
    wire logic inv    = cfl_q.map != 2'h0;
    wire logic cfg_ev = tg2_q ^ tg3_q;

    // Serial clock gating and phase events
    wire logic clk_en = is_ser && (tx_active || rx_active)
                        && (blind || (tx_active && !tx_hdr) || rx_sync);
    wire logic tog    = clk_en && div_q == 4'(SER_DIV - 1);
    wire logic s_rise = tog && !sclk_q;
    wire logic s_fall = tog && sclk_q;

    // Transmit source selection
    wire logic hdr_str  = is_ser && tx_hdr && !blind;
    wire logic rdy      = tx_active && !half_q && (is_fif || hdr_str);
    wire logic take_f   = rdy && tx_bit_valid;
    wire logic take_s   = is_ser && tx_active && (blind || !tx_hdr) && s_rise && !half_q;
    wire logic take     = take_f || take_s;
    wire logic src_bit  = take_f ? tx_bit : sd2_q;

    // Chip stream with Manchester on payload only
    wire logic man_on = cfl_q.man && !tx_hdr;
    wire logic chip_v = take || half_q;
    wire logic chip   = half_q ? ~held_q : src_bit;
    wire logic pay4   = four && !tx_hdr;
    wire logic emit   = chip_v && (!pay4 || pair_q);
    wire logic [1:0] lvl2 = {chip ^ inv, chip ^ inv};
    wire logic [1:0] lvl4 = map_lvl({first_q, chip}, cfl_q.map);

    // Receive demapping and Manchester decode
    wire logic rx_take = rx_sym_valid && rx_active && !rx_hdr && !is_trn;
    wire logic [1:0] rx_d4 = unmap_lvl(rx_sym_lvl, cfl_q.map);
    wire logic rx_b2 = rx_sym_lvl[1] ^ inv;
    wire logic [1:0] rx_n = !rx_take ? 2'h0 :
                            four ? (cfl_q.man ? 2'h1 : 2'h2) :
                            (cfl_q.man && rph_q) ? 2'h0 : 2'h1;
    wire logic [1:0] rx_b = four ? (cfl_q.man ? {1'h0, rx_d4[1]} : rx_d4) : {1'h0, rx_b2};
    wire logic push = is_ser && rx_n != 2'h0;
    wire logic pop  = s_fall && pc_q != 2'h0;

    // Reset, host data pin and configuration toggle synchronisers
    always_ff @(posedge link_clk) begin
        rs1_q <= sys_rst;
        lrst  <= rs1_q;
        sd1_q <= ser_tx_data;
        sd2_q <= sd1_q;
        tg1_q <= cfg_tog_q;
        tg2_q <= tg1_q;
        tg3_q <= tg2_q;
    end

    // Configuration copy and status levels
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            cfl_q  <= dmsm_pkg::CFG_RST;
            st_l_q <= 3'h0;
        end else begin
            if (cfg_ev) cfl_q <= cfg_q;
            st_l_q <= {tx_active && !tx_hdr, rx_sync, clk_en};
        end
    end

    // Serial bit clock made by the device
    always_ff @(posedge link_clk) begin
        if (lrst || !clk_en) begin
            div_q  <= 4'h0;
            sclk_q <= 1'h0;
        end else begin
            div_q  <= tog ? 4'h0 : div_q + 4'h1;
            sclk_q <= tog ? ~sclk_q : sclk_q;
        end
    end

    // Transmit chips and symbol output
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            half_q  <= 1'h0;
            held_q  <= 1'h0;
            pair_q  <= 1'h0;
            first_q <= 1'h0;
            sym_v_q <= 1'h0;
            sym_q   <= '0;
        end else begin
            half_q <= take && man_on;
            if (take) held_q <= src_bit;
            if (chip_v && pay4) pair_q <= ~pair_q;
            if (chip_v && !pair_q) first_q <= chip;
            sym_v_q    <= emit;
            sym_q.hdr  <= tx_hdr;
            sym_q.ask  <= cfl_q.mod == dmsm_pkg::MOD_ASK;
            sym_q.shaped <= gauss;
            sym_q.lvl  <= pay4 ? lvl4 : lvl2;
        end
    end

    // Receive bits to buffer or serial pin, baseband pass-through
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            rxb_q  <= '0;
            rph_q  <= 1'h0;
            pq_q   <= 2'h0;
            pc_q   <= 2'h0;
            sdat_q <= 1'h0;
            raw_q  <= 1'h0;
        end else begin
            rxb_q <= is_fif ? {rx_n, rx_b} : 4'h0;
            if (rx_take && !four) rph_q <= cfl_q.man && !rph_q;
            if (push) begin
                pq_q <= rx_b;
                pc_q <= rx_n;
            end else if (pop) begin
                pc_q <= pc_q - 2'h1;
            end
            if (pop) sdat_q <= (pc_q == 2'h2) ? pq_q[1] : pq_q[0];
            raw_q <= is_trn && rx_hard;
        end
    end

    assign tx_bit_ready = rdy;
    assign tx_sym       = sym_q;
    assign tx_sym_valid = sym_v_q;
    assign rx_bits      = rxb_q;
    assign ser_clk      = sclk_q;
    assign ser_rx_data  = sdat_q;
    assign raw_baseband = raw_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions on the link domain

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (lrst);

    a_fifo_ready_gate: assert property (
        (!is_fif && !hdr_str) |-> !tx_bit_ready)
        else $error("buffer ready outside buffered mode");
    a_fifo_rx_bit: assert property (
        (is_fif && rx_take && !four && !cfl_q.man) |=>
        (rx_bits.cnt == 2'h1 && rx_bits.bits[0] == $past(rx_b2)))
        else $error("received bit not delivered");
    a_hdr_auto_take: assert property (
        (tx_active && tx_hdr && (is_fif || hdr_str) && !half_q) |-> tx_bit_ready)
        else $error("header bits not accepted");
    a_sync_clk_off: assert property (
        (is_ser && !blind && !rx_sync && !(tx_active && !tx_hdr)) |=> !ser_clk)
        else $error("serial clock before sync");
    a_blind_clk_runs: assert property (
        (blind && rx_active)[*8] |-> (ser_clk != $past(ser_clk, SER_DIV)))
        else $error("blind serial clock stalled");
    a_raw_pass: assert property (
        is_trn[*2] |-> (raw_baseband == $past(rx_hard) && !tx_bit_ready))
        else $error("baseband not passed through");
    a_man_halves: assert property (
        (take && man_on && !pay4) |-> ##1 tx_sym_valid ##1
        (tx_sym_valid && tx_sym.lvl[1] != $past(tx_sym.lvl[1])))
        else $error("Manchester halves not opposite");
    a_hdr_uncoded: assert property (
        (take && tx_hdr) |=> !half_q)
        else $error("header bit was coded");
    a_hdr_two_lvl: assert property (
        (tx_sym_valid && tx_sym.hdr) |-> (tx_sym.lvl[1] == tx_sym.lvl[0]))
        else $error("header symbol not two-level");
    a_map_bits: assert property (
        (take && !man_on && !pay4) |=>
        (tx_sym_valid && tx_sym.lvl[1] == ($past(src_bit) ^ $past(inv))))
        else $error("bit mapped to wrong sign");
    a_ser_edge: assert property (
        $changed(ser_rx_data) |-> !ser_clk)
        else $error("serial data changed with clock high");

    // Main scenarios
    c_blind_clock: cover property (blind && $rose(ser_clk));
    c_transparent: cover property (is_trn && $rose(raw_baseband));
    c_four_inner:  cover property (tx_sym_valid && !tx_sym.hdr && tx_sym.lvl[1] != tx_sym.lvl[0]);
    c_manchester:  cover property (take && man_on);

endmodule : dmsm_mapper

/* dmsm_host_model.sv */
// Host microcontroller model on the serial and raw baseband pins
`timescale 1ns/1ps
module dmsm_host_model (
    input  wire logic ser_clk,
    input  wire logic ser_rx_data,
    input  wire logic raw_baseband,
    input  wire logic tx_level,
    output logic      ser_tx_data,
    output logic      rx_last,
    output int        raw_rises
);
    // Start values before any clock appears
    initial begin
        ser_tx_data = 1'b0;
        rx_last = 1'b0;
        raw_rises = 0;
    end

    // Takes device data at the rising clock, no frame alignment assumed
    always @(posedge ser_clk) begin
        rx_last <= ser_rx_data;
    end

    // Moves own data after the falling clock so it is steady at the rise
    always @(negedge ser_clk) begin
        ser_tx_data <= tx_level;
    end

    // Pulse counting: decoding of the raw signal stays with the host
    always @(posedge raw_baseband) begin
        raw_rises <= raw_rises + 1;
    end
endmodule : dmsm_host_model

/* data_mode_and_symbol_mapper_bench.sv */
// Testbench of the data mode and symbol mapper
`timescale 1ns/1ps
module data_mode_and_symbol_mapper_bench;
    logic                mclk, sys_rst, link_clk, reg_wr, reg_rd;
    logic [7:0]          reg_addr, reg_wdata, reg_rdata;
    logic [15:0]         dev_units;
    logic                tx_active, tx_hdr, tx_bit_valid, tx_bit, tx_bit_ready, tx_sym_valid;
    logic                rx_active, rx_sync, rx_hdr, rx_sym_valid, rx_hard;
    logic [1:0]          rx_sym_lvl;
    logic                ser_clk, ser_rx_data, ser_tx_data, raw_baseband, host_last, host_tx;
    dmsm_pkg::dmsm_sym_t tx_sym;
    dmsm_pkg::dmsm_rxb_t rx_bits;
    dmsm_pkg::dmsm_sym_t sq[$];
    dmsm_pkg::dmsm_rxb_t rq[$];
    int                  err_total, cmp_count, clk_hi, raw_rises, i;

    dmsm_mapper #(.SER_DIV(4)) u_dmsm_mapper (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_units(dev_units),
        .link_clk(link_clk), .tx_active(tx_active), .tx_hdr(tx_hdr),
        .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit), .tx_bit_ready(tx_bit_ready),
        .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid), .rx_active(rx_active),
        .rx_sync(rx_sync), .rx_hdr(rx_hdr), .rx_sym_valid(rx_sym_valid),
        .rx_sym_lvl(rx_sym_lvl), .rx_hard(rx_hard), .rx_bits(rx_bits), .ser_clk(ser_clk),
        .ser_rx_data(ser_rx_data), .ser_tx_data(ser_tx_data), .raw_baseband(raw_baseband));

    dmsm_host_model u_dmsm_host_model (
        .ser_clk(ser_clk), .ser_rx_data(ser_rx_data), .raw_baseband(raw_baseband),
        .tx_level(host_tx), .ser_tx_data(ser_tx_data), .rx_last(host_last),
        .raw_rises(raw_rises));

    ////////////////////////////////////////////////////////////////////////////
    // Clocks, unrelated in phase
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #62.5 link_clk = ~link_clk;
    end

    // Collects symbols, received bits and serial clock activity
    always @(posedge link_clk) begin
        if (tx_sym_valid === 1'b1) sq.push_back(tx_sym);
        if (rx_bits.cnt !== 2'h0) rq.push_back(rx_bits);
        if (ser_clk === 1'b1) clk_hi++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd_chk

    task automatic lwait(input int n);
        repeat (n) @(posedge link_clk);
    endtask : lwait

    // Offers one bit and holds it until the take edge
    task automatic tx_send(input logic b);
        int n;
        @(posedge link_clk);
        tx_bit_valid <= 1'b1;
        tx_bit <= b;
        for (n = 0; n < 20; n++) begin
            @(posedge link_clk);
            if (tx_bit_ready === 1'b1) break;
        end
        tx_bit_valid <= 1'b0;
        if (n == 20) begin
            err_total++;
            complete_run();
        end
    endtask : tx_send

    task automatic rx_send(input logic [1:0] lvl);
        @(posedge link_clk);
        rx_sym_valid <= 1'b1;
        rx_sym_lvl <= lvl;
        @(posedge link_clk);
        rx_sym_valid <= 1'b0;
        lwait(6);
    endtask : rx_send

    // Two bits under one scheme; checks count and last symbol
    task automatic tx_case(input logic [2:0] m, input logic h, input logic b1, input logic b0,
                           input logic [1:0] lvl, input logic [15:0] n);
        wr(dmsm_pkg::A_MOD_AND_EXP, {2'h0, m, 3'h0});
        lwait(10);
        tx_active <= 1'b1;
        tx_hdr <= h;
        sq.delete();
        tx_send(b1);
        tx_send(b0);
        lwait(6);
        chk(16'(sq.size()), n);
        if (sq.size() > 0) begin
            chk(sq[$].lvl, lvl);
            chk(sq[$].ask, m == 3'h3);
            chk(sq[$].shaped, m == 3'h1 || m == 3'h5);
            chk(sq[$].hdr, h);
        end
        tx_active <= 1'b0;
    endtask : tx_case

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {tx_active, tx_hdr, tx_bit_valid, tx_bit, host_tx} = '0;
        {rx_active, rx_sync, rx_hdr, rx_sym_valid, rx_sym_lvl, rx_hard} = '0;
        err_total = 0;
        cmp_count = 0;
        clk_hi = 0;
        sys_rst = 1'b1;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        lwait(4);
        chk(dev_units, 16'h0000);
        rd_chk(dmsm_pkg::A_MOD_AND_EXP, 8'h00);
        rd_chk(8'h40, 8'h00);
        // Deviation: zero exponent, maximum exponent, exponent one
        wr(dmsm_pkg::A_DEV_MANTISSA, 8'h55);
        repeat (3) @(posedge mclk);
        #1 chk(dev_units, 16'h00AA);
        wr(dmsm_pkg::A_DEV_MANTISSA, 8'hFF);
        wr(dmsm_pkg::A_MOD_AND_EXP, 8'h07);
        repeat (3) @(posedge mclk);
        #1 chk(dev_units, 16'hFF80);
        rd_chk(dmsm_pkg::A_MOD_AND_EXP, 8'h07);
        wr(dmsm_pkg::A_DEV_MANTISSA, 8'h00);
        wr(dmsm_pkg::A_MOD_AND_EXP, 8'h01);
        repeat (3) @(posedge mclk);
        #1 chk(dev_units, 16'h0200);
        // Symbol mapping under each scheme
        tx_case(3'h0, 1'b0, 1'b1, 1'b0, 2'h0, 16'h2);
        tx_case(3'h3, 1'b0, 1'b0, 1'b1, 2'h3, 16'h2);
        tx_case(3'h1, 1'b0, 1'b1, 1'b1, 2'h3, 16'h2);
        tx_case(3'h4, 1'b0, 1'b0, 1'b0, 2'h1, 16'h1);
        tx_case(3'h4, 1'b0, 1'b0, 1'b1, 2'h0, 16'h1);
        tx_case(3'h4, 1'b0, 1'b1, 1'b0, 2'h2, 16'h1);
        tx_case(3'h5, 1'b0, 1'b1, 1'b1, 2'h3, 16'h1);
        tx_case(3'h4, 1'b1, 1'b1, 1'b0, 2'h0, 16'h2);
        // Manchester payload doubles symbols; pre-coded header pair stays plain
        wr(dmsm_pkg::A_MODEM_CONFIG_ONE, 8'h01);
        tx_case(3'h0, 1'b0, 1'b1, 1'b1, 2'h0, 16'h4);
        tx_case(3'h0, 1'b1, 1'b1, 1'b0, 2'h0, 16'h2);
        wr(dmsm_pkg::A_MODEM_CONFIG_ONE, 8'h00);
        // Other symbol maps on transmit
        wr(dmsm_pkg::A_MODEM_CONFIG_TWO, 8'h01);
        tx_case(3'h0, 1'b0, 1'b0, 1'b1, 2'h0, 16'h2);
        tx_case(3'h4, 1'b0, 1'b1, 1'b1, 2'h2, 16'h1);
        wr(dmsm_pkg::A_MODEM_CONFIG_TWO, 8'h02);
        tx_case(3'h4, 1'b0, 1'b0, 1'b1, 2'h3, 16'h1);
        wr(dmsm_pkg::A_MODEM_CONFIG_TWO, 8'h03);
        tx_case(3'h4, 1'b0, 1'b1, 1'b0, 2'h0, 16'h1);
        // Four-level receive under map 11 gives dibit 01
        rx_active <= 1'b1;
        rq.delete();
        rx_send(2'h2);
        chk(16'(rq.size()), 16'h1);
        if (rq.size() == 1) chk(rq[0], 16'h9);
        rx_active <= 1'b0;
        wr(dmsm_pkg::A_MODEM_CONFIG_TWO, 8'h00);
        // Buffered receive delivers bits
        wr(dmsm_pkg::A_MOD_AND_EXP, 8'h00);
        lwait(10);
        rx_active <= 1'b1;
        rx_sync <= 1'b1;
        rq.delete();
        rx_send(2'h3);
        rx_send(2'h0);
        chk(16'(rq.size()), 16'h2);
        if (rq.size() == 2) chk({rq[0].bits[0], rq[1].bits[0]}, 16'h2);
        // Serial mode: clock held until sync, then data to host
        rx_active <= 1'b0;
        rx_sync <= 1'b0;
        wr(dmsm_pkg::A_PACKET_CONFIG_TWO, 8'h01);
        lwait(10);
        rx_active <= 1'b1;
        clk_hi = 0;
        lwait(40);
        chk(16'(clk_hi), 16'h0);
        rx_sync <= 1'b1;
        repeat (6) rx_send(2'h3);
        chk(host_last, 1'b1);
        chk(clk_hi > 0, 1'b1);
        rd_chk(dmsm_pkg::A_LINK_STATUS, 8'h03);
        repeat (6) rx_send(2'h0);
        chk(host_last, 1'b0);
        rx_active <= 1'b0;
        rx_sync <= 1'b0;
        // Blind serial mode: clock runs with no sync, host data taken at the rise
        wr(dmsm_pkg::A_SYNC_CONFIG_ONE, 8'h00);
        lwait(10);
        rx_active <= 1'b1;
        tx_active <= 1'b1;
        tx_hdr <= 1'b0;
        host_tx <= 1'b0;
        clk_hi = 0;
        lwait(40);
        chk(clk_hi > 0, 1'b1);
        rd_chk(dmsm_pkg::A_LINK_STATUS, 8'h05);
        sq.delete();
        lwait(40);
        chk(sq.size() > 0, 1'b1);
        if (sq.size() > 0) chk(sq[$].lvl, 2'h0);
        host_tx <= 1'b1;
        lwait(40);
        if (sq.size() > 0) chk(sq[$].lvl, 2'h3);
        tx_active <= 1'b0;
        rx_active <= 1'b0;
        // Transparent mode: raw level passes, transmit path refuses
        wr(dmsm_pkg::A_PACKET_CONFIG_TWO, 8'h03);
        lwait(10);
        tx_active <= 1'b1;
        tx_bit_valid <= 1'b1;
        for (i = 0; i < 4; i++) begin
            @(posedge link_clk) rx_hard <= ~rx_hard;
            @(posedge link_clk);
            #1 chk(raw_baseband, rx_hard);
            chk(tx_bit_ready, 1'b0);
        end
        tx_bit_valid <= 1'b0;
        chk(16'(raw_rises), 16'h2);
        complete_run();
    end
endmodule : data_mode_and_symbol_mapper_bench
